/* File: rtl/ssc_pkg.sv */
package ssc_pkg;
    // Synchroniser depth for the asynchronous sideband requests
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        SSC_RUN,
        SSC_SMI_SAVE,
        SSC_SMI_ACK,
        SSC_GRANT_ACK,
        SSC_GRANT,
        SSC_SLEEP
    } ssc_state_t;

    // Bus transaction requests toward the bus interface unit
    typedef struct packed {
        logic smi_ack;
        logic grant_ack;
    } ssc_bus_req_t;

    // Clock gating enables per unit group
    typedef struct packed {
        logic core;
        logic bus_apic;
    } ssc_clk_en_t;
endpackage : ssc_pkg

/* File: rtl/ssc_ctrl.sv */
`timescale 1ns/1ns
// Operation
// [RL1] System logic may assert the management interrupt request at any time, unaligned to the clock.
// [RL2] On accepting a management interrupt the device saves its state and enters management mode.
// [RL3] In management mode the device issues an acknowledge bus transaction, then runs the handler.
// [RL4] An asserted halt-clock request moves the device into the low-power stop-grant state.
// [RL5] Entering stop-grant the device issues a stop-grant acknowledge bus transaction.
// [RL6] In stop-grant all core unit clocks are gated except bus interface and interrupt unit.
// [RL7] In stop-grant snoops are still answered and incoming interrupts may be held pending.
// [RL8] On release of the halt-clock request clocks return, execution resumes, pending irq served.
// [RL9] The halt-clock request never touches the bus clock and is handled as asynchronous.
// [RL10] A deep-halt request in stop-grant enters sleep; its release returns to stop-grant.
// [RL11] In sleep snoops and interrupts are ignored; only sleep, halt-clock and reset matter. Here sleep ignores halt-clock: only the sleep request and reset act.
// [RL12] Every asynchronous sideband request passes a multi-stage synchroniser before use.
// [RL13] A management interrupt is accepted only at an instruction boundary.
module ssc_ctrl
    import ssc_pkg::*;
(
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         sys_mgmt_irq_n_in,
    input  wire logic         halt_clock_req_n_in,
    input  wire logic         deep_halt_req_n_in,
    input  wire logic         instr_boundary_in,
    input  wire logic         state_saved_in,
    input  wire logic         bus_ack_done_in,
    input  wire logic         snoop_req_in,
    input  wire logic         irq_in,
    input  wire logic         irq_taken_in,
    input  wire logic         rsm_in,
    output logic              state_save_req_out,
    output ssc_bus_req_t      bus_req_out,
    output logic              sys_mgmt_mode_out,
    output logic              handler_start_out,
    output ssc_clk_en_t       clk_en_out,
    output logic              snoop_en_out,
    output logic              irq_pending_out,
    output logic              resume_out,
    output ssc_state_t        state_out
);

    logic [SYNC_STAGES-1:0] smi_sync;
    logic [SYNC_STAGES-1:0] stp_sync;
    logic [SYNC_STAGES-1:0] slp_sync;
    ssc_state_t             state;
    ssc_state_t             next_state;
    logic                   sys_mgmt_mode;
    logic                   next_sys_mgmt_mode;
    logic                   irq_pending;
    logic                   next_irq_pending;
    logic                   handler_start;
    logic                   resume;

    // Core clocks are off in stop-grant proper and in sleep
    function automatic logic core_gated(input ssc_state_t s);
        core_gated = (s == SSC_GRANT) || (s == SSC_SLEEP);
    endfunction : core_gated

    // Interrupts may latch in the acknowledge phase and in stop-grant, not in sleep
    function automatic logic in_grant(input ssc_state_t s);
        in_grant = (s == SSC_GRANT) || (s == SSC_GRANT_ACK);
    endfunction : in_grant

    // One synchroniser step: new pin level enters at bit 0
    function automatic logic [SYNC_STAGES-1:0] sync_shift(
        input logic [SYNC_STAGES-1:0] chain,
        input logic                   pin
    );
        sync_shift = {chain[SYNC_STAGES-2:0], pin};
    endfunction : sync_shift

    // Inputs idle high; chains reset to the inactive level so no false request follows reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smi_sync <= '1;
        end else begin
            smi_sync <= sync_shift(smi_sync, sys_mgmt_irq_n_in); // [RL1] [RL12]
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stp_sync <= '1;
        end else begin
            stp_sync <= sync_shift(stp_sync, halt_clock_req_n_in); // [RL9] [RL12]
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slp_sync <= '1;
        end else begin
            slp_sync <= sync_shift(slp_sync, deep_halt_req_n_in); // [RL12]
        end
    end

    // Only the last stage is read, the first may still be metastable
    wire smi_req    = ~smi_sync[SYNC_STAGES-1]; // [RL12]
    wire stp_req    = ~stp_sync[SYNC_STAGES-1]; // [RL12]
    wire slp_req    = ~slp_sync[SYNC_STAGES-1]; // [RL12]

    // A request held during management mode waits by pin level
    wire smi_take   = smi_req && !sys_mgmt_mode && instr_boundary_in; // [RL13]
    wire grant_exit = (state == SSC_GRANT) && !slp_req && !stp_req; // [RL8]
    wire enter_smm  = (state == SSC_SMI_ACK) && bus_ack_done_in; // [RL3]
    wire irq_latch  = irq_in && in_grant(state); // [RL7]
    wire irq_clear  = irq_taken_in && (state == SSC_RUN); // [RL8]
    wire mode_set   = (state == SSC_SMI_SAVE); // [RL2]
    wire mode_clear = rsm_in && (state == SSC_RUN);

    // Stop-clock outranks a new SMI; SMI waits until clocks resume
    always_comb begin
        next_state = state;
        case (state)
            SSC_RUN: begin
                if (stp_req) begin
                    next_state = SSC_GRANT_ACK; // [RL4]
                end else if (smi_take) begin
                    next_state = SSC_SMI_SAVE; // [RL2] [RL13]
                end
            end
            SSC_SMI_SAVE: begin
                if (state_saved_in) begin
                    next_state = SSC_SMI_ACK; // [RL2]
                end
            end
            SSC_SMI_ACK: begin
                if (bus_ack_done_in) begin
                    next_state = SSC_RUN; // [RL3]
                end
            end
            SSC_GRANT_ACK: begin
                if (bus_ack_done_in) begin
                    next_state = SSC_GRANT; // [RL5]
                end
            end
            SSC_GRANT: begin
                if (slp_req) begin
                    next_state = SSC_SLEEP; // [RL10]
                end else if (!stp_req) begin
                    next_state = SSC_RUN; // [RL8]
                end
            end
            SSC_SLEEP: begin
                // Nothing but the sleep request moves the machine here
                if (!slp_req) begin
                    next_state = SSC_GRANT; // [RL10] [RL11]
                end
            end
            default: begin
                next_state = SSC_RUN;
            end
        endcase
    end

    // Mode set and clear live in different states, so they never meet
    assign next_sys_mgmt_mode = mode_set ? 1'b1 : (mode_clear ? 1'b0 : sys_mgmt_mode); // [RL2]

    // Set wins over clear so a late interrupt is not lost
    assign next_irq_pending = irq_latch ? 1'b1 : (irq_clear ? 1'b0 : irq_pending); // [RL7] [RL8]

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= SSC_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_mgmt_mode <= 1'b0;
        end else begin
            sys_mgmt_mode <= next_sys_mgmt_mode; // [RL2]
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_pending <= 1'b0;
        end else begin
            irq_pending <= next_irq_pending; // [RL7]
        end
    end

    // Pulses are registered so they line up with the new state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            handler_start <= 1'b0;
            resume        <= 1'b0;
        end else begin
            handler_start <= enter_smm; // [RL3]
            resume        <= grant_exit; // [RL8]
        end
    end

    // Bus clock is not controlled here at all, only internal enables
    assign clk_en_out.core     = !core_gated(state); // [RL6] [RL9]
    assign clk_en_out.bus_apic = (state != SSC_SLEEP); // [RL6] [RL11]
    assign snoop_en_out        = (state != SSC_SLEEP); // [RL7] [RL11]
    assign bus_req_out.smi_ack   = (state == SSC_SMI_ACK); // [RL3]
    assign bus_req_out.grant_ack = (state == SSC_GRANT_ACK); // [RL5]
    assign state_save_req_out  = (state == SSC_SMI_SAVE); // [RL2]
    assign sys_mgmt_mode_out   = sys_mgmt_mode;
    assign handler_start_out   = handler_start;
    assign irq_pending_out     = irq_pending;
    assign resume_out          = resume;
    assign state_out           = state;

endmodule : ssc_ctrl

/* File: sim/ssc_props.sv */
`timescale 1ns/1ns
module ssc_props import ssc_pkg::*; (
    input wire logic    sys_clk_in, rst_n_in, halt_clock_req_n_in, bus_ack_done_in,
    input wire logic    state_save_req_out, sys_mgmt_mode_out, handler_start_out, snoop_en_out,
    input wire logic    resume_out,
    input ssc_bus_req_t bus_req_out,
    input ssc_clk_en_t  clk_en_out,
    input ssc_state_t   state_out);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_save_req: assert property (state_save_req_out == (state_out == SSC_SMI_SAVE))
        else $error("save request off");
    chk_mode_entry: assert property (state_out == SSC_SMI_SAVE |=> sys_mgmt_mode_out)
        else $error("mode not entered");
    chk_handler_go: assert property (state_out == SSC_SMI_ACK && bus_ack_done_in |=> handler_start_out)
        else $error("no handler start");
    chk_ack_hold: assert property (|bus_req_out && !bus_ack_done_in |=> $stable(bus_req_out))
        else $error("bus request dropped");
    chk_grant_gate: assert property (state_out == SSC_GRANT |-> clk_en_out == 2'b01 && snoop_en_out)
        else $error("grant gating");
    chk_sleep_gate: assert property (state_out == SSC_SLEEP |-> clk_en_out == 2'b00 && !snoop_en_out)
        else $error("sleep gating");
    chk_run_clocks: assert property (state_out == SSC_RUN |-> clk_en_out == 2'b11)
        else $error("run clocks off");
    chk_sync_lag: assert property ($fell(halt_clock_req_n_in) |=> state_out != SSC_GRANT_ACK)
        else $error("request not synced");
    cover property (state_out == SSC_SLEEP);
    cover property (handler_start_out);
    cover property (resume_out);
endmodule : ssc_props

/* File: sim/ssc_chip.sv */
`timescale 1ns/1ns
module ssc_chip import ssc_pkg::*; (
    input  wire logic   clk_in, smi_in, stp_in, slp_in,
    input  ssc_bus_req_t req_in,
    output logic        smi_n_out, stp_n_out, slp_n_out, done_out);
    // Pins follow the bench one edge later, by nonblocking update, so no read races
    always @(posedge clk_in) begin
        {smi_n_out, stp_n_out, slp_n_out} <= ~{smi_in, stp_in, slp_in};
    end
    // Acknowledge done is a one-cycle pulse per request
    always @(negedge clk_in) begin
        done_out <= |req_in && !done_out;
    end
endmodule : ssc_chip

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
    import ssc_pkg::*;
    logic clk = 0, rst_n = 0, smi = 0, stp = 0, slp = 0, bnd = 0, svd = 0, irq = 0, tkn = 0, rsm = 0;
    logic smi_n, stp_n, slp_n, done, sreq, mode, hs, snp, pend, res;
    ssc_bus_req_t breq;
    ssc_clk_en_t  cen;
    ssc_state_t   st;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    ssc_chip u_chip (.clk_in(clk), .smi_in(smi), .stp_in(stp), .slp_in(slp), .req_in(breq),
        .smi_n_out(smi_n), .stp_n_out(stp_n), .slp_n_out(slp_n), .done_out(done));
    ssc_ctrl DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .sys_mgmt_irq_n_in(smi_n),
        .halt_clock_req_n_in(stp_n), .deep_halt_req_n_in(slp_n), .instr_boundary_in(bnd),
        .state_saved_in(svd), .bus_ack_done_in(done), .snoop_req_in(1'b0), .irq_in(irq),
        .irq_taken_in(tkn), .rsm_in(rsm), .state_save_req_out(sreq), .bus_req_out(breq),
        .sys_mgmt_mode_out(mode), .handler_start_out(hs), .clk_en_out(cen),
        .snoop_en_out(snp), .irq_pending_out(pend), .resume_out(res), .state_out(st));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc > 3000) begin n_mismatch++; complete_run; end
    task chk(input logic [2:0] seen, input logic [2:0] exp);
        cmp_count++;
        if (seen !== exp) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, seen, exp); end
    endtask : chk
    task wt(input int n); repeat (n) @(negedge clk); endtask : wt
    // Bounded wait: a stuck machine is reported, not hung on
    task wst(input ssc_state_t s);
        for (int i = 0; i < 20 && st !== s; i++) @(negedge clk);
        chk(st, s);
    endtask : wst
    task t_smi;
        smi = 1; wt(8);
        chk(st, SSC_RUN);
        bnd = 1; wst(SSC_SMI_SAVE);
        smi = 0; chk(sreq, 3'h1);
        svd = 1; wst(SSC_SMI_ACK);
        svd = 0; chk(breq, 3'h2);
        wst(SSC_RUN);
        chk(hs, 3'h1);
        smi = 1; wt(8);
        chk(st, SSC_RUN);
        smi = 0; wt(4);
        chk(mode, 3'h1);
        rsm = 1; wt(1); rsm = 0; wt(1);
        chk(mode, 3'h0);
    endtask : t_smi
    task t_stop;
        stp = 1; irq = 1; wst(SSC_GRANT);
        irq = 0; chk(cen, 3'h1);
        chk({snp, pend}, 3'h3);
        slp = 1; wst(SSC_SLEEP);
        chk({cen, snp}, 3'h0);
        slp = 0; wst(SSC_GRANT);
        stp = 0; wst(SSC_RUN);
        chk(res, 3'h1);
        chk({cen, pend}, 3'h7);
        tkn = 1; wt(1); tkn = 0; wt(1);
        chk(pend, 3'h0);
    endtask : t_stop
    task complete_run;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        wt(3); rst_n = 1; wt(2);
        t_smi; t_stop; complete_run;
    end
endmodule : tb
bind ssc_ctrl ssc_props u_props (.*);
